// ==== src/temp_fault_response.sv ====
// Functional notes
// - Die overtemperature sets summary bit in status word and mfr overtemp flag.
// - Any temperature fault asserts the alert line.
// - Die action response code 00 or 01 is rejected with CML fault.
// - Response 10 disables output at once, then follows retry field.
// - Die response 11 holds output off only while fault persists.
// - Die retry 000 keeps output off until the fault is cleared.
// - Die retry values 001 to 111 are rejected with CML fault.
// - Delay field in low three bits of die action is ignored.
// - Fault flags clear only by clear command, run cycle or power.
// - Ext overtemp action is paged byte at 0x50, default 0xB8.
// - Ext undertemp action is paged byte at 0x54, default 0xB8.
// - Ext overtemp sets temperature summary bit and overtemp flag.
// - Ext faults come from ADC, reaction may lag up to 90ms.
// - Ext overtemp action command carries exactly one data byte.
// - Ext response 00 keeps channel running after flagging.
// - Ext retry 111 restarts each interval until off or bias lost.
// - Ext undertemp sets undertemp flag in temperature status.
`default_nettype none
module temp_fault_response
    import temp_fault_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    input  wire logic                 cmd_valid,
    input  wire logic                 cmd_write,
    input  wire logic [7:0]           cmd_code,
    input  wire logic [7:0]           cmd_byte_count,
    input  wire logic [7:0]           cmd_wdata,
    output logic      [15:0]          rd_data,
    output logic                      rd_valid,
    input  wire logic                 die_ot_fault,
    input  wire logic [NUM_PAGES-1:0] ext_ot_fault,
    input  wire logic [NUM_PAGES-1:0] ext_ut_fault,
    input  wire logic [NUM_PAGES-1:0] output_run_pin,
    input  wire logic [NUM_PAGES-1:0] operation_on,
    input  wire logic                 restart_tick,
    output logic      [NUM_PAGES-1:0] output_enable,
    output logic                      alert_out,
    output logic                      alert_oe_n
);
    logic [7:0]           page_q, page_d;
    logic [7:0]           ot_act_q [NUM_PAGES];
    logic [7:0]           ot_act_d [NUM_PAGES];
    logic [7:0]           ut_act_q [NUM_PAGES];
    logic [7:0]           ut_act_d [NUM_PAGES];
    logic [7:0]           die_act_q, die_act_d;
    logic                 cml_q, cml_d;
    logic [15:0]          rd_data_q, rd_data_d;
    logic                 rd_valid_q, rd_valid_d;
    logic                 alert_q, alert_d;
    logic                 wr, rd, clear, bad;
    logic                 sel;
    logic [NUM_PAGES-1:0] f_die, f_ot, f_ut;
    logic [7:0]           st_byte, st_temp, st_mfr;

    page_if pg_if [NUM_PAGES] ();

    assign wr    = cmd_valid && cmd_write;
    assign rd    = cmd_valid && !cmd_write;
    assign clear = wr && cmd_code == CMD_CLEAR_FAULTS;
    assign sel   = page_q[0];

    // one engine and own ot and ut action copies per page; die action shared
    for (genvar i = 0; i < NUM_PAGES; i++) begin : g_page
        assign pg_if[i].ot_action    = ot_act_q[i];
        assign pg_if[i].ut_action    = ut_act_q[i];
        assign pg_if[i].die_action   = die_act_q;
        assign pg_if[i].run_cmd      = output_run_pin[i] && operation_on[i];
        assign pg_if[i].clear        = clear;
        assign pg_if[i].restart_tick = restart_tick;
        assign pg_if[i].die_fault    = die_ot_fault;
        // ADC lag is upstream, no extra delay here
        assign pg_if[i].ext_ot_fault = ext_ot_fault[i];
        assign pg_if[i].ext_ut_fault = ext_ut_fault[i];
        assign f_die[i]              = pg_if[i].flag_die_ot;
        assign f_ot[i]               = pg_if[i].flag_ext_ot;
        assign f_ut[i]               = pg_if[i].flag_ext_ut;
        assign output_enable[i]      = pg_if[i].output_en;
        temp_page_engine u_engine (
            .sys_clk (sys_clk),
            .rst_n   (rst_n),
            .pg      (pg_if[i])
        );
    end

    always_comb begin
        st_byte = 8'h00;
        st_temp = 8'h00;
        st_mfr  = 8'h00;
        st_byte[SB_TEMP_BIT] = f_ot[sel] || f_ut[sel];
        st_byte[SB_CML_BIT]  = cml_q;
        st_temp[ST_OT_BIT]   = f_ot[sel];
        st_temp[ST_UT_BIT]   = f_ut[sel];
        st_mfr[SM_OT_BIT]    = f_die[sel];
    end

    always_comb begin
        page_d     = page_q;
        ot_act_d   = ot_act_q;
        ut_act_d   = ut_act_q;
        die_act_d  = die_act_q;
        cml_d      = cml_q;
        rd_data_d  = rd_data_q;
        rd_valid_d = rd;
        bad        = 1'b0;
        if (wr) begin
            case (cmd_code)
                CMD_CLEAR_FAULTS: begin
                    bad = cmd_byte_count != 8'h00;
                end
                CMD_PAGE: begin
                    bad = cmd_byte_count != 8'h01 || cmd_wdata >= 8'(NUM_PAGES);
                    if (!bad) begin
                        page_d = cmd_wdata;
                    end
                end
                CMD_EXT_OT: begin
                    bad = cmd_byte_count != 8'h01
                        || cmd_wdata[RESP_HI:RESP_LO] == RESP_BAD
                        || cmd_wdata[RESP_HI:RESP_LO] == RESP_HOLD;
                    if (!bad) begin
                        ot_act_d[sel] = cmd_wdata;
                    end
                end
                CMD_EXT_UT: begin
                    bad = cmd_byte_count != 8'h01
                        || cmd_wdata[RESP_HI:RESP_LO] == RESP_BAD
                        || cmd_wdata[RESP_HI:RESP_LO] == RESP_HOLD;
                    if (!bad) begin
                        ut_act_d[sel] = cmd_wdata;
                    end
                end
                CMD_DIE_OT: begin
                    bad = cmd_byte_count != 8'h01
                        || !cmd_wdata[RESP_HI]
                        || cmd_wdata[RETRY_HI:RETRY_LO] != RETRY_NONE;
                    if (!bad) begin
                        die_act_d = cmd_wdata;
                    end
                end
                default: bad = 1'b1;
            endcase
        end else if (rd) begin
            case (cmd_code)
                CMD_PAGE:        rd_data_d = {8'h00, page_q};
                CMD_EXT_OT:      rd_data_d = {8'h00, ot_act_q[sel]};
                CMD_EXT_UT:      rd_data_d = {8'h00, ut_act_q[sel]};
                CMD_DIE_OT:      rd_data_d = {8'h00, die_act_q};
                CMD_STATUS_BYTE: rd_data_d = {8'h00, st_byte};
                CMD_STATUS_TEMP: rd_data_d = {8'h00, st_temp};
                CMD_STATUS_MFR:  rd_data_d = {8'h00, st_mfr};
                CMD_STATUS_WORD: begin
                    rd_data_d             = {8'h00, st_byte};
                    rd_data_d[SW_MFR_BIT] = f_die[sel];
                end
                default: begin
                    rd_data_d = 16'h0000;
                    bad       = 1'b1;
                end
            endcase
        end
        if (clear) begin
            cml_d = 1'b0;
        end
        if (bad) begin
            cml_d = 1'b1;
        end
        alert_d = cml_d || (|(f_die | f_ot | f_ut)) || die_ot_fault
            || (|ext_ot_fault) || (|ext_ut_fault);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            page_q     <= PAGE_RST;
            ot_act_q   <= '{default: EXT_ACTION_RST};
            ut_act_q   <= '{default: EXT_ACTION_RST};
            die_act_q  <= DIE_ACTION_RST;
            cml_q      <= 1'b0;
            rd_data_q  <= 16'h0000;
            rd_valid_q <= 1'b0;
            alert_q    <= 1'b0;
        end else begin
            page_q     <= page_d;
            ot_act_q   <= ot_act_d;
            ut_act_q   <= ut_act_d;
            die_act_q  <= die_act_d;
            cml_q      <= cml_d;
            rd_data_q  <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            alert_q    <= alert_d;
        end
    end

    assign rd_data    = rd_data_q;
    assign rd_valid   = rd_valid_q;
    assign alert_out  = 1'b0;
    assign alert_oe_n = !alert_q;

    chk_alert_fault: assert property (@(posedge sys_clk) disable iff (!rst_n)
        die_ot_fault || (|ext_ot_fault) || (|ext_ut_fault) |=> !alert_oe_n)
        else $error("alert not raised");
    chk_die_code_rej: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr && cmd_code == CMD_DIE_OT && !cmd_wdata[RESP_HI] |=> cml_q && $stable(die_act_q))
        else $error("bad die response accepted");
    chk_die_retry_rej: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr && cmd_code == CMD_DIE_OT && cmd_wdata[RETRY_HI:RETRY_LO] != RETRY_NONE
        |=> cml_q && $stable(die_act_q))
        else $error("bad die retry accepted");
    chk_one_byte: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr && cmd_code == CMD_EXT_OT && cmd_byte_count != 8'h01
        |=> cml_q && $stable(ot_act_q[sel]))
        else $error("byte count not checked");
    chk_die_word: assert property (@(posedge sys_clk) disable iff (!rst_n)
        die_ot_fault ##1 rd && cmd_code == CMD_STATUS_WORD |=> rd_data[SW_MFR_BIT])
        else $error("mfr summary bit missing");
    cov_cml:   cover property (@(posedge sys_clk) wr && bad);
    cov_clear: cover property (@(posedge sys_clk) clear && alert_q);
endmodule
`default_nettype wire

// ==== src/temp_fault_pkg.sv ====
`default_nettype none
package temp_fault_pkg;
    localparam int unsigned NUM_PAGES = 2;
    // Command codes
    localparam logic [7:0] CMD_PAGE         = 8'h00;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_EXT_OT       = 8'h50;
    localparam logic [7:0] CMD_EXT_UT       = 8'h54;
    localparam logic [7:0] CMD_STATUS_BYTE  = 8'h78;
    localparam logic [7:0] CMD_STATUS_WORD  = 8'h79;
    localparam logic [7:0] CMD_STATUS_TEMP  = 8'h7D;
    localparam logic [7:0] CMD_STATUS_MFR   = 8'h80;
    localparam logic [7:0] CMD_DIE_OT       = 8'hD6;
    // Reset values
    localparam logic [7:0] EXT_ACTION_RST   = 8'hB8;
    localparam logic [7:0] DIE_ACTION_RST   = 8'hC0;
    localparam logic [7:0] PAGE_RST         = 8'h00;
    // Action byte fields
    localparam int unsigned RESP_HI  = 7;
    localparam int unsigned RESP_LO  = 6;
    localparam int unsigned RETRY_HI = 5;
    localparam int unsigned RETRY_LO = 3;
    localparam logic [1:0] RESP_IGNORE  = 2'h0;
    localparam logic [1:0] RESP_BAD     = 2'h1;
    localparam logic [1:0] RESP_SHUT    = 2'h2;
    localparam logic [1:0] RESP_HOLD    = 2'h3;
    localparam logic [2:0] RETRY_NONE   = 3'h0;
    localparam logic [2:0] RETRY_ALWAYS = 3'h7;
    // Status bit positions
    localparam int unsigned SB_TEMP_BIT = 2;
    localparam int unsigned SB_CML_BIT  = 1;
    localparam int unsigned SW_MFR_BIT  = 12;
    localparam int unsigned ST_OT_BIT   = 7;
    localparam int unsigned ST_UT_BIT   = 4;
    localparam int unsigned SM_OT_BIT   = 1;
    // ADC-based detection lag of external faults
    localparam int unsigned EXT_LATENCY_MS = 90;
    typedef enum logic [2:0] {
        PG_OFF     = 3'b001,
        PG_ON      = 3'b010,
        PG_LATCHED = 3'b100
    } page_state_t;
endpackage
`default_nettype wire

// ==== src/page_if.sv ====
`default_nettype none
interface page_if;
    logic [7:0] ot_action;
    logic [7:0] ut_action;
    logic [7:0] die_action;
    logic       run_cmd;
    logic       clear;
    logic       restart_tick;
    logic       die_fault;
    logic       ext_ot_fault;
    logic       ext_ut_fault;
    logic       flag_die_ot;
    logic       flag_ext_ot;
    logic       flag_ext_ut;
    logic       output_en;
    modport engine (input ot_action, ut_action, die_action, run_cmd, clear, restart_tick,
                    die_fault, ext_ot_fault, ext_ut_fault,
                    output flag_die_ot, flag_ext_ot, flag_ext_ut, output_en);
    modport ctrl (output ot_action, ut_action, die_action, run_cmd, clear, restart_tick,
                  die_fault, ext_ot_fault, ext_ut_fault,
                  input flag_die_ot, flag_ext_ot, flag_ext_ut, output_en);
endinterface
`default_nettype wire

// ==== src/temp_page_engine.sv ====
`default_nettype none
module temp_page_engine
    import temp_fault_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst_n,
    page_if.engine    pg
);
    page_state_t state_q, state_d;
    logic [2:0]  flags_q, flags_d;
    logic        retry_ok_q, retry_ok_d;
    logic        en_q, en_d;
    logic [1:0]  ot_resp, ut_resp, die_resp;
    logic        ot_retry, ut_retry;
    logic        ot_shut, ut_shut, die_shut, die_hold, ext_live;

    assign ot_resp  = pg.ot_action[RESP_HI:RESP_LO];
    assign ut_resp  = pg.ut_action[RESP_HI:RESP_LO];
    assign die_resp = pg.die_action[RESP_HI:RESP_LO];
    assign ot_retry = pg.ot_action[RETRY_HI:RETRY_LO] == RETRY_ALWAYS;
    assign ut_retry = pg.ut_action[RETRY_HI:RETRY_LO] == RETRY_ALWAYS;
    assign ot_shut  = pg.ext_ot_fault && ot_resp == RESP_SHUT;
    assign ut_shut  = pg.ext_ut_fault && ut_resp == RESP_SHUT;
    assign die_shut = pg.die_fault && die_resp == RESP_SHUT;
    assign die_hold = pg.die_fault && die_resp == RESP_HOLD;
    assign ext_live = pg.ext_ot_fault || pg.ext_ut_fault;

    always_comb begin
        flags_d    = flags_q;
        state_d    = state_q;
        retry_ok_d = retry_ok_q;
        // sticky until clear or run cycle
        if (pg.clear || (state_q == PG_OFF && pg.run_cmd)) begin
            flags_d = 3'h0;
        end
        flags_d = flags_d | {pg.ext_ut_fault, pg.ext_ot_fault, pg.die_fault};
        case (state_q)
            PG_OFF: begin
                if (pg.run_cmd) begin
                    state_d = PG_ON;
                end
            end
            PG_ON: begin
                if (!pg.run_cmd) begin
                    state_d = PG_OFF;
                end else if (ot_shut || ut_shut || die_shut) begin
                    state_d    = PG_LATCHED;
                    retry_ok_d = !die_shut && (!ot_shut || ot_retry) && (!ut_shut || ut_retry);
                end
            end
            PG_LATCHED: begin
                if (die_shut || (ot_shut && !ot_retry) || (ut_shut && !ut_retry)) begin
                    retry_ok_d = 1'b0;
                end
                if (!pg.run_cmd) begin
                    state_d = PG_OFF;
                end else if (retry_ok_d && pg.restart_tick && !ext_live && !pg.die_fault) begin
                    state_d = PG_ON;
                end else if (pg.clear && !ext_live && !pg.die_fault) begin
                    state_d = PG_ON;
                end
            end
            default: state_d = PG_OFF;
        endcase
        // hold off while die fault present
        en_d = state_d == PG_ON && !die_hold;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q    <= PG_OFF;
            flags_q    <= 3'h0;
            retry_ok_q <= 1'b0;
            en_q       <= 1'b0;
        end else begin
            state_q    <= state_d;
            flags_q    <= flags_d;
            retry_ok_q <= retry_ok_d;
            en_q       <= en_d;
        end
    end

    assign pg.flag_die_ot = flags_q[0];
    assign pg.flag_ext_ot = flags_q[1];
    assign pg.flag_ext_ut = flags_q[2];
    assign pg.output_en   = en_q;

    chk_shut_now: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_q == PG_ON && pg.run_cmd && ot_shut |=> !en_q && state_q == PG_LATCHED)
        else $error("output not shut on fault");
    chk_hold_resume: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_q == PG_ON && pg.run_cmd && !ot_shut && !ut_shut && !pg.die_fault
        && die_resp == RESP_HOLD && $past(die_hold) |=> en_q)
        else $error("output not resumed after hold");
    chk_no_restart: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_q == PG_LATCHED && !retry_ok_q && !pg.clear |=> !en_q)
        else $error("restart without clear");
    chk_flag_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
        flags_q[1] && !pg.clear && !(state_q == PG_OFF && pg.run_cmd) |=> flags_q[1])
        else $error("fault flag dropped");
    chk_ext_ot_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pg.ext_ot_fault |=> pg.flag_ext_ot)
        else $error("ext ot flag missing");
    chk_ut_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pg.ext_ut_fault |=> pg.flag_ext_ut)
        else $error("ut flag missing");
    chk_keep_running: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_q == PG_ON && pg.run_cmd && !pg.die_fault && ext_live
        && (!pg.ext_ot_fault || ot_resp == RESP_IGNORE)
        && (!pg.ext_ut_fault || ut_resp == RESP_IGNORE) |=> en_q)
        else $error("output stopped under ignore");
    chk_retry_go: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_q == PG_LATCHED && retry_ok_q && pg.run_cmd && pg.restart_tick
        && !ext_live && !pg.die_fault |=> en_q)
        else $error("retry not attempted");
    cov_latch: cover property (@(posedge sys_clk) state_q == PG_LATCHED);
    cov_retry: cover property (@(posedge sys_clk) state_q == PG_LATCHED ##1 state_q == PG_ON);
    cov_hold:  cover property (@(posedge sys_clk) die_hold && state_q == PG_ON);
endmodule
`default_nettype wire

// ==== dv/alert_host_model.sv ====
`default_nettype none
module alert_host_model (
    input  wire logic alert_out,
    input  wire logic alert_oe_n,
    output logic      alert_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // Host pull-up holds the released line high
    assign alert_line = alert_oe_n ? 1'b1 : alert_out;
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module testbench
    import temp_fault_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 sys_clk;
    logic                 rst_n;
    logic                 cmd_valid;
    logic                 cmd_write;
    logic [7:0]           cmd_code;
    logic [7:0]           cmd_byte_count;
    logic [7:0]           cmd_wdata;
    logic [15:0]          rd_data;
    logic                 rd_valid;
    logic                 die_ot_fault;
    logic [NUM_PAGES-1:0] ext_ot_fault;
    logic [NUM_PAGES-1:0] ext_ut_fault;
    logic [NUM_PAGES-1:0] output_run_pin;
    logic [NUM_PAGES-1:0] operation_on;
    logic                 restart_tick;
    logic [NUM_PAGES-1:0] output_enable;
    logic                 alert_out;
    logic                 alert_oe_n;
    logic                 alert_line;
    int                   fail_count = 0;
    int                   checks = 0;
    logic [7:0]           bad_die [4] = '{8'h00, 8'h40, 8'h88, 8'hB8};

    temp_fault_response dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_byte_count(cmd_byte_count), .cmd_wdata(cmd_wdata),
        .rd_data(rd_data), .rd_valid(rd_valid), .die_ot_fault(die_ot_fault),
        .ext_ot_fault(ext_ot_fault), .ext_ut_fault(ext_ut_fault),
        .output_run_pin(output_run_pin), .operation_on(operation_on),
        .restart_tick(restart_tick), .output_enable(output_enable),
        .alert_out(alert_out), .alert_oe_n(alert_oe_n)
    );
    alert_host_model host (.alert_out(alert_out), .alert_oe_n(alert_oe_n),
                           .alert_line(alert_line));

    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;

    task automatic final_report();
        if (fail_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic send(input logic wr, input logic [7:0] code, input logic [7:0] cnt,
                        input logic [7:0] data);
        @(posedge sys_clk);
        cmd_valid      <= 1'b1;
        cmd_write      <= wr;
        cmd_code       <= code;
        cmd_byte_count <= cnt;
        cmd_wdata      <= data;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        #1;
    endtask

    task automatic wr_byte(input logic [7:0] code, input logic [7:0] data);
        send(1'b1, code, 8'h01, data);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] code, input logic [15:0] msk,
                          input logic [15:0] exp);
        send(1'b0, code, 8'h00, 8'h00);
        `CHK("rd_valid", 1'b1, rd_valid)
        `CHK(nm, exp, rd_data & msk)
    endtask

    task automatic clear_all();
        send(1'b1, CMD_CLEAR_FAULTS, 8'h00, 8'h00);
    endtask

    task automatic en_chk(input logic [1:0] exp);
        `CHK("output_enable", exp, output_enable)
    endtask

    task automatic wait_en(input logic [1:0] exp, input int n);
        #1;
        for (int i = 0; i < n && output_enable !== exp; i++) cyc(1);
        en_chk(exp);
    endtask

    task automatic tick();
        @(posedge sys_clk);
        restart_tick <= 1'b1;
        @(posedge sys_clk);
        restart_tick <= 1'b0;
        cyc(2);
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        final_report();
    end

    initial begin
        rst_n = 1'b0;
        {cmd_valid, cmd_write, die_ot_fault, restart_tick} = 4'h0;
        {cmd_code, cmd_byte_count, cmd_wdata} = 24'h000000;
        {ext_ot_fault, ext_ut_fault, output_run_pin, operation_on} = 8'h00;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        cyc(1);
        en_chk(2'b00);
        `CHK("alert_idle", 1'b1, alert_line)
        for (int p = 1; p >= 0; p--) begin
            wr_byte(CMD_PAGE, 8'(p));
            rd_chk("ot_action", CMD_EXT_OT, 16'hFFFF, 16'h00B8);
            rd_chk("ut_action", CMD_EXT_UT, 16'hFFFF, 16'h00B8);
        end
        foreach (bad_die[i]) begin
            wr_byte(CMD_DIE_OT, bad_die[i]);
            rd_chk("cml_die", CMD_STATUS_BYTE, 16'h0002, 16'h0002);
            clear_all();
            rd_chk("cml_clr", CMD_STATUS_BYTE, 16'h0002, 16'h0000);
        end
        rd_chk("die_keep", CMD_DIE_OT, 16'h00FF, {8'h00, DIE_ACTION_RST});
        send(1'b1, CMD_EXT_OT, 8'h02, 8'h80);
        rd_chk("cml_count", CMD_STATUS_BYTE, 16'h0002, 16'h0002);
        rd_chk("ot_keep", CMD_EXT_OT, 16'h00FF, 16'h00B8);
        clear_all();
        @(posedge sys_clk);
        output_run_pin <= 2'b11;
        operation_on   <= 2'b11;
        cyc(3);
        en_chk(2'b11);
        @(posedge sys_clk);
        die_ot_fault <= 1'b1;
        cyc(1);
        en_chk(2'b00);
        cyc(1);
        `CHK("alert_die", 1'b0, alert_line)
        rd_chk("word_mfr", CMD_STATUS_WORD, 16'h1000, 16'h1000);
        rd_chk("mfr_ot", CMD_STATUS_MFR, 16'h0002, 16'h0002);
        @(posedge sys_clk);
        die_ot_fault <= 1'b0;
        wait_en(2'b11, 3);
        rd_chk("mfr_hold", CMD_STATUS_MFR, 16'h0002, 16'h0002);
        clear_all();
        rd_chk("mfr_clr", CMD_STATUS_MFR, 16'h0002, 16'h0000);
        wr_byte(CMD_DIE_OT, 8'h87);
        rd_chk("cml_delay", CMD_STATUS_BYTE, 16'h0002, 16'h0000);
        @(posedge sys_clk);
        die_ot_fault <= 1'b1;
        cyc(1);
        en_chk(2'b00);
        @(posedge sys_clk);
        die_ot_fault <= 1'b0;
        cyc(4);
        en_chk(2'b00);
        @(posedge sys_clk);
        operation_on <= 2'b00;
        cyc(2);
        @(posedge sys_clk);
        operation_on <= 2'b11;
        wait_en(2'b11, 3);
        rd_chk("mfr_cycle", CMD_STATUS_MFR, 16'h0002, 16'h0000);
        wr_byte(CMD_EXT_OT, 8'h80);
        @(posedge sys_clk);
        ext_ot_fault <= 2'b01;
        cyc(1);
        en_chk(2'b10);
        cyc(1);
        `CHK("alert_ext", 1'b0, alert_line)
        @(posedge sys_clk);
        ext_ot_fault <= 2'b00;
        cyc(4);
        en_chk(2'b10);
        rd_chk("temp_ot", CMD_STATUS_TEMP, 16'h0080, 16'h0080);
        rd_chk("byte_temp", CMD_STATUS_BYTE, 16'h0004, 16'h0004);
        wr_byte(CMD_PAGE, 8'h01);
        rd_chk("temp_p1", CMD_STATUS_TEMP, 16'h0080, 16'h0000);
        wr_byte(CMD_PAGE, 8'h00);
        @(posedge sys_clk);
        output_run_pin <= 2'b10;
        cyc(2);
        @(posedge sys_clk);
        output_run_pin <= 2'b11;
        wait_en(2'b11, 3);
        rd_chk("temp_cycle", CMD_STATUS_TEMP, 16'h0080, 16'h0000);
        wr_byte(CMD_EXT_OT, 8'hB8);
        @(posedge sys_clk);
        ext_ot_fault <= 2'b01;
        cyc(1);
        en_chk(2'b10);
        tick();
        en_chk(2'b10);
        @(posedge sys_clk);
        ext_ot_fault <= 2'b00;
        cyc(3);
        en_chk(2'b10);
        tick();
        wait_en(2'b11, 3);
        clear_all();
        wr_byte(CMD_PAGE, 8'h01);
        wr_byte(CMD_EXT_UT, 8'h00);
        @(posedge sys_clk);
        ext_ut_fault <= 2'b10;
        cyc(3);
        en_chk(2'b11);
        rd_chk("temp_ut", CMD_STATUS_TEMP, 16'h0010, 16'h0010);
        @(posedge sys_clk);
        ext_ut_fault <= 2'b00;
        clear_all();
        rd_chk("ut_clr", CMD_STATUS_TEMP, 16'h0010, 16'h0000);
        @(posedge sys_clk);
        die_ot_fault <= 1'b1;
        cyc(2);
        rd_chk("mfr_pre", CMD_STATUS_MFR, 16'h0002, 16'h0002);
        @(posedge sys_clk);
        rst_n        <= 1'b0;
        die_ot_fault <= 1'b0;
        cyc(2);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        cyc(1);
        en_chk(2'b11);
        `CHK("alert_rst", 1'b1, alert_line)
        rd_chk("mfr_rst", CMD_STATUS_MFR, 16'h0002, 16'h0000);
        final_report();
    end
endmodule
`undef CHK
`default_nettype wire
